// *** hdl/pmv_top.sv ***
// Purpose: checks scanned strings against stored presets, counts matches
//          and pulses the ten parallel result lines
// Assumes: scanner stream is synchronous to SYS_CLK; POWER_DOWN is a pin
// Notes:   one preset compared per cycle; first matching preset wins
// Behaviour
// - scan equal to a preset increments that preset's counter.
// - scan matching no preset increments counter zero.
// - matching preset number is shown on the preset number output.
// - every counter saturates at 999,999.
// - manual trigger acts as a match of the selected preset.
// - software may overwrite the selected preset's counter.
// - one setting clears or keeps counters on power-down and table update.
// - setting selects bit, binary or BCD result coding.
// - BCD puts hundreds on lines 10-9, tens 8-5, units 4-1.
// - bit coding signals only numbers 1 to 10.
// - pulse width 10 ms to 2.55 s, default 500 ms.
// - assertion delay 0 to 255 ms, default 5 ms.
// - normal mode compares the scan with presets 1 to 16 in turn, stopping at the first match.
// - single mode compares only the selected preset.
// - single mode reports only pass line or mismatch line.
// - one-character wildcard matches any character at its place.
// - run wildcard matches any sequence; only one per entry.
`timescale 1ns/1ps
module pmv_top #(
  parameter int MS_CYCLES = pmv_pkg::MS_CYCLES
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        SCAN_VALID,
  input  wire logic [7:0]  SCAN_CHAR,
  input  wire logic        SCAN_LAST,
  output logic             SCAN_READY,
  input  wire logic        POWER_DOWN,
  output logic [9:0]       RESULT_LINES,
  output logic             MISMATCH_LINE,
  output logic [4:0]       PRESET_NUM
);
  localparam int SW = pmv_pkg::CHARS * 8;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic str_match(input logic [SW-1:0] p,
                                     input logic [4:0]    pl,
                                     input logic [SW-1:0] s,
                                     input logic [4:0]    sl);
    logic [4:0] b;
    logic [4:0] k;
    logic [7:0] pc;
    logic       ok;
    b = pl;
    k = 5'h00;
    pc = 8'h00;
    for (int i = pmv_pkg::CHARS - 1; i >= 0; i--) begin
      if (5'(i) < pl && p[i*8 +: 8] == pmv_pkg::WILD_RUN) begin
        b = 5'(i);
      end
    end
    ok = (b == pl) ? (sl == pl) : ({1'b0, sl} + 6'h01 >= {1'b0, pl});
    for (int i = 0; i < pmv_pkg::CHARS; i++) begin
      k = (5'(i) < b) ? 5'(i) : 5'(sl - pl + 5'(i));
      pc = p[i*8 +: 8];
      if (5'(i) < pl && 5'(i) != b && pc != pmv_pkg::WILD_ONE &&
          pc != s[{k[3:0], 3'b000} +: 8]) begin
        ok = 1'b0;
      end
    end
    return ok && (pl != 5'h00);
  endfunction

  // axi write and read side
  logic              aw_full_reg;
  logic              w_full_reg;
  logic [7:0]        aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;

  // core state
  pmv_pkg::pmv_state_e state_reg;
  pmv_pkg::pmv_ctrl_s  ctrl_reg;
  pmv_pkg::pmv_time_s  time_reg;
  pmv_pkg::pmv_out_s   pend_reg;
  pmv_pkg::pmv_out_s   out_reg;
  logic [4:0]        sel_reg;
  logic [4:0]        idx_reg;
  logic [4:0]        num_reg;
  logic              pass_reg;
  logic              miss_reg;
  logic              trig_reg;
  logic [SW-1:0]     scan_reg;
  logic [4:0]        slen_reg;
  logic              ovf_reg;
  logic [11:0]       timer_reg;
  logic [23:0]       pre_reg;
  logic [2:0]        pd_sync_reg;
  logic              pd_lvl_reg;
  logic [SW-1:0]     pre_data_reg [0:pmv_pkg::NPRE];
  logic [4:0]        pre_len_reg  [0:pmv_pkg::NPRE];
  logic [19:0]       cnt_mem      [0:pmv_pkg::NPRE];

  wire         wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
  wire [7:0]   wa      = aw_addr_reg;
  wire [31:0]  wd      = w_data_reg;
  wire         wr_ctrl = wr_fire && wa == pmv_pkg::A_CTRL;
  wire         wr_trig = wr_fire && wa == pmv_pkg::A_TRIG;
  wire         wr_sel  = wr_fire && wa == pmv_pkg::A_SEL;
  wire         wr_time = wr_fire && wa == pmv_pkg::A_TIME;
  wire         wr_cnt  = wr_fire && wa == pmv_pkg::A_COUNT;
  wire         wr_chr  = wr_fire && wa == pmv_pkg::A_PCHAR;
  wire         wr_len  = wr_fire && wa == pmv_pkg::A_PLEN;
  wire         wr_ok   = wr_ctrl || wr_trig || wr_sel || wr_time ||
                         wr_cnt || wr_chr || wr_len;
  wire [4:0]   wr_pidx = wd[pmv_pkg::P_IDX_LSB +: 5];
  wire         pidx_ok = wr_pidx != 5'h00 && wr_pidx <= 5'(pmv_pkg::NPRE);
  wire [31:0]  sel_new = merge({27'h0, sel_reg}, wd, w_strb_reg);
  wire [31:0]  cnt_new = merge({12'h0, cnt_mem[sel_reg]}, wd, w_strb_reg);
  wire [31:0]  ctl_new = merge({27'h0, ctrl_reg}, wd, w_strb_reg);
  wire [31:0]  tim_new = merge({16'h0, time_reg}, wd, w_strb_reg);
  wire [4:0]   len_new = (wd[4:0] > 5'(pmv_pkg::CHARS)) ?
                         5'(pmv_pkg::CHARS) : wd[4:0];

  // read decode
  wire [7:0]   ra = S_AXI_ARADDR;
  wire         rd_hit = ra == pmv_pkg::A_CTRL || ra == pmv_pkg::A_TRIG ||
                        ra == pmv_pkg::A_SEL || ra == pmv_pkg::A_TIME ||
                        ra == pmv_pkg::A_STAT || ra == pmv_pkg::A_COUNT ||
                        ra == pmv_pkg::A_PCHAR || ra == pmv_pkg::A_PLEN;
  wire pmv_pkg::pmv_stat_s stat = '{state: state_reg, miss: miss_reg,
                                    pass: pass_reg, num: num_reg};
  logic [31:0] rd_val;
  always_comb begin
    if (ra == pmv_pkg::A_CTRL) begin
      rd_val = {27'h0, ctrl_reg};
    end else if (ra == pmv_pkg::A_SEL) begin
      rd_val = {27'h0, sel_reg};
    end else if (ra == pmv_pkg::A_TIME) begin
      rd_val = {16'h0, time_reg};
    end else if (ra == pmv_pkg::A_STAT) begin
      rd_val = {23'h0, stat};
    end else if (ra == pmv_pkg::A_COUNT) begin
      rd_val = {12'h0, cnt_mem[sel_reg]};
    end else begin
      rd_val = 32'h0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= pmv_pkg::RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= pmv_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= {S_AXI_AWADDR[7:2], 2'b00};
      end else if (wr_fire) begin
        aw_full_reg <= 1'b0;
      end
      if (S_AXI_WVALID && !w_full_reg) begin
        w_full_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end else if (wr_fire) begin
        w_full_reg <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_ok ? pmv_pkg::RESP_OKAY : pmv_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
      if (S_AXI_ARVALID && !rvalid_reg) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_hit ? rd_val : 32'h0;
        rresp_reg  <= rd_hit ? pmv_pkg::RESP_OKAY : pmv_pkg::RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign S_AXI_AWREADY = !aw_full_reg;
  assign S_AXI_WREADY  = !w_full_reg;
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign S_AXI_ARREADY = !rvalid_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RDATA   = rdata_reg;
  assign S_AXI_RRESP   = rresp_reg;

  // power-down pin: level accepted when stages two and three agree
  wire pd_agree = pd_sync_reg[1] == pd_sync_reg[2];
  wire pd_rise  = pd_agree && pd_sync_reg[2] && !pd_lvl_reg;

  wire in_idle  = state_reg == pmv_pkg::S_IDLE;
  wire scan_beat = in_idle && SCAN_VALID;
  wire cmp_hit  = !ovf_reg && str_match(pre_data_reg[idx_reg],
                    pre_len_reg[idx_reg], scan_reg, slen_reg);
  wire man_go   = in_idle && trig_reg && slen_reg == 5'h00 && !SCAN_VALID;
  wire cmp_end  = state_reg == pmv_pkg::S_COMP && (cmp_hit ||
                  ctrl_reg.single || idx_reg == 5'(pmv_pkg::NPRE));
  wire fin      = man_go || cmp_end;
  wire fin_hit  = man_go || cmp_hit;
  wire [4:0] fin_num = man_go ? sel_reg : idx_reg;
  // matched counter, counter zero on miss
  wire [4:0] cnt_idx = fin_hit ? fin_num : 5'h00;
  wire cnt_inc  = fin && ctrl_reg.cnt_en;
  // clear on power-down or table update
  wire cnt_clr  = !ctrl_reg.retain && (pd_rise || wr_len || wr_chr);
  wire ms_tick  = pre_reg == 24'(MS_CYCLES - 1);

  // coding select, bit range, binary lsb, bcd digits
  wire [9:0] bit_lines = (fin_num != 5'h00 && fin_num <= 5'd10) ?
                         10'(10'h001 << (fin_num - 5'h01)) : 10'h000;
  wire [9:0] bin_lines = {5'h00, fin_num};
  wire [9:0] bcd_lines = {2'(fin_num / 7'd100), 4'((fin_num / 5'd10) % 5'd10),
                          4'(fin_num % 5'd10)};
  wire [9:0] num_lines = (ctrl_reg.enc == pmv_pkg::ENC_BIN) ? bin_lines :
                         (ctrl_reg.enc == pmv_pkg::ENC_BCD) ? bcd_lines :
                         bit_lines;
  // single mode gives pass line only
  wire [9:0] hit_lines = ctrl_reg.single ? 10'h001 : num_lines;
  wire [11:0] width_ms = 12'(pmv_pkg::PULSE_UNIT_MS) *
                         ((time_reg.width_10ms == 8'h00) ? 12'h001 :
                          {4'h0, time_reg.width_10ms});

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_reg   <= pmv_pkg::S_IDLE;
      ctrl_reg    <= pmv_pkg::CTRL_RST;
      time_reg    <= pmv_pkg::TIME_RST;
      pend_reg    <= '0;
      out_reg     <= '0;
      sel_reg     <= 5'h01;
      idx_reg     <= 5'h01;
      num_reg     <= 5'h00;
      pass_reg    <= 1'b0;
      miss_reg    <= 1'b0;
      trig_reg    <= 1'b0;
      scan_reg    <= '0;
      slen_reg    <= 5'h00;
      ovf_reg     <= 1'b0;
      timer_reg   <= 12'h000;
      pre_reg     <= 24'h0;
      pd_sync_reg <= 3'b000;
      pd_lvl_reg  <= 1'b0;
      for (int i = 0; i <= pmv_pkg::NPRE; i++) begin
        pre_len_reg[i] <= 5'h00;
      end
    end else begin
      pd_sync_reg <= {pd_sync_reg[1:0], POWER_DOWN};
      if (pd_agree) begin
        pd_lvl_reg <= pd_sync_reg[2];
      end
      if (wr_ctrl) begin
        ctrl_reg <= pmv_pkg::pmv_ctrl_s'(ctl_new[4:0]);
      end
      if (wr_time) begin
        time_reg <= pmv_pkg::pmv_time_s'(tim_new[15:0]);
      end
      if (wr_sel && sel_new[4:0] != 5'h00 &&
          sel_new[4:0] <= 5'(pmv_pkg::NPRE)) begin
        sel_reg <= sel_new[4:0];
      end
      if (wr_chr && pidx_ok) begin
        pre_data_reg[wr_pidx][{wd[pmv_pkg::P_POS_LSB +: 4], 3'b000} +: 8]
          <= wd[7:0];
      end
      if (wr_len && pidx_ok) begin
        pre_len_reg[wr_pidx] <= len_new;
      end
      // new trigger beats its own consumption
      trig_reg <= (trig_reg && !man_go) || (wr_trig && wd[pmv_pkg::TRIG_BIT]);
      pre_reg  <= (ms_tick || fin) ? 24'h0 : pre_reg + 24'h1;
      case (state_reg)
        pmv_pkg::S_IDLE: begin
          if (scan_beat) begin
            if (slen_reg < 5'(pmv_pkg::CHARS)) begin
              scan_reg[{slen_reg[3:0], 3'b000} +: 8] <= SCAN_CHAR;
              slen_reg <= slen_reg + 5'h01;
            end else begin
              ovf_reg <= 1'b1;
            end
            if (SCAN_LAST) begin
              state_reg <= pmv_pkg::S_COMP;
              idx_reg   <= ctrl_reg.single ? sel_reg : 5'h01;
            end
          end
        end
        pmv_pkg::S_COMP: begin
          if (!cmp_end) begin
            idx_reg <= idx_reg + 5'h01;
          end
        end
        pmv_pkg::S_DELAY: begin
          if (timer_reg == 12'h000) begin
            state_reg <= pmv_pkg::S_PULSE;
            out_reg   <= pend_reg;
            timer_reg <= width_ms;
            pre_reg   <= 24'h0;
          end else if (ms_tick) begin
            timer_reg <= timer_reg - 12'h001;
          end
        end
        default: begin
          if (ms_tick) begin
            timer_reg <= timer_reg - 12'h001;
            if (timer_reg <= 12'h001) begin
              state_reg <= pmv_pkg::S_IDLE;
              out_reg   <= '0;
            end
          end
        end
      endcase
      if (fin) begin
        state_reg <= pmv_pkg::S_DELAY;
        timer_reg <= {4'h0, time_reg.delay_ms};
        pend_reg  <= '{mismatch: !fin_hit,
                       lines: fin_hit ? hit_lines : 10'h000};
        pass_reg  <= fin_hit;
        miss_reg  <= !fin_hit;
        slen_reg  <= 5'h00;
        ovf_reg   <= 1'b0;
        if (fin_hit) begin
          num_reg <= fin_num;
        end
      end
    end
  end

  for (genvar g = 0; g <= pmv_pkg::NPRE; g++) begin : g_cnt
    logic [19:0] cnt_reg;
    always_ff @(posedge SYS_CLK) begin
      if (RESET || cnt_clr) begin
        cnt_reg <= 20'h0;
      end else if (wr_cnt && sel_reg == 5'(g)) begin
        cnt_reg <= (cnt_new > 32'(pmv_pkg::CNT_MAX)) ?
                   pmv_pkg::CNT_MAX : cnt_new[19:0];
      end else if (cnt_inc && cnt_idx == 5'(g) &&
                   cnt_reg != pmv_pkg::CNT_MAX) begin
        cnt_reg <= cnt_reg + 20'h1;
      end
    end
    assign cnt_mem[g] = cnt_reg;
  end

  assign SCAN_READY    = in_idle;
  assign RESULT_LINES  = out_reg.lines;
  assign MISMATCH_LINE = out_reg.mismatch;
  assign PRESET_NUM    = num_reg;
endmodule // pmv_top

// *** hdl/pmv_pkg.sv ***
// Purpose: shared constants and types of the preset match verifier
// Assumes: 250 MHz clock, AXI4-Lite register access
// Notes:   field layouts are carried by the packed structs below
package pmv_pkg;
  localparam int NPRE  = 16;
  localparam int CHARS = 16;
  localparam logic [19:0] CNT_MAX  = 20'hf423f;
  localparam logic [7:0]  WILD_ONE = 8'h3f;
  localparam logic [7:0]  WILD_RUN = 8'h21;

  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_TRIG  = 8'h04;
  localparam logic [7:0] A_SEL   = 8'h08;
  localparam logic [7:0] A_TIME  = 8'h0c;
  localparam logic [7:0] A_STAT  = 8'h10;
  localparam logic [7:0] A_COUNT = 8'h14;
  localparam logic [7:0] A_PCHAR = 8'h18;
  localparam logic [7:0] A_PLEN  = 8'h1c;

  localparam int P_IDX_LSB = 16;
  localparam int P_POS_LSB = 8;
  localparam int TRIG_BIT  = 0;

  localparam int PULSE_UNIT_MS = 10;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int MS_PS         = 1000000000;
  localparam int MS_CYCLES     = MS_PS / CLK_PERIOD_PS;
  localparam logic [7:0] WIDTH_RST = 8'h32;
  localparam logic [7:0] DELAY_RST = 8'h05;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ENC_BIT = 2'b00,
    ENC_BIN = 2'b01,
    ENC_BCD = 2'b10
  } pmv_enc_e;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_COMP  = 2'b01,
    S_DELAY = 2'b10,
    S_PULSE = 2'b11
  } pmv_state_e;

  typedef struct packed {
    logic     retain;
    logic     cnt_en;
    logic     single;
    pmv_enc_e enc;
  } pmv_ctrl_s;

  typedef struct packed {
    logic [7:0] delay_ms;
    logic [7:0] width_10ms;
  } pmv_time_s;

  typedef struct packed {
    logic [1:0] state;
    logic       miss;
    logic       pass;
    logic [4:0] num;
  } pmv_stat_s;

  typedef struct packed {
    logic       mismatch;
    logic [9:0] lines;
  } pmv_out_s;

  localparam pmv_ctrl_s CTRL_RST = '{retain: 1'b1, cnt_en: 1'b1,
                                     single: 1'b0, enc: ENC_BIT};
  localparam pmv_time_s TIME_RST = '{delay_ms: DELAY_RST,
                                     width_10ms: WIDTH_RST};
endpackage

// *** tb/pmv_sva.sv ***
// Purpose: port-level checks of the preset match verifier
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to every pmv_top instance
`timescale 1ns/1ps
module pmv_sva #(
  parameter int MS_CYCLES = 4
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  input  wire logic        S_AXI_AWVALID,
  input  wire logic        S_AXI_AWREADY,
  input  wire logic        S_AXI_WVALID,
  input  wire logic        S_AXI_WREADY,
  input  wire logic        S_AXI_BVALID,
  input  wire logic        S_AXI_ARVALID,
  input  wire logic        S_AXI_ARREADY,
  input  wire logic [31:0] S_AXI_RDATA,
  input  wire logic        S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        SCAN_READY,
  input  wire logic [9:0]  RESULT_LINES,
  input  wire logic        MISMATCH_LINE,
  input  wire logic [4:0]  PRESET_NUM
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  logic        out_on;
  logic [31:0] hi_cnt_reg;
  assign out_on = (|RESULT_LINES) | MISMATCH_LINE;
  // length of the current result pulse
  always_ff @(posedge SYS_CLK) begin
    if (RESET || !out_on) hi_cnt_reg <= '0;
    else hi_cnt_reg <= hi_cnt_reg + 32'h1;
  end
  sequence s_wr_both;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_pulse_end;
    $fell(out_on);
  endsequence
  property p_wr_resp;
    s_wr_both |-> ##2 S_AXI_BVALID;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  property p_rd_resp;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  property p_r_hold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_excl;
    MISMATCH_LINE |-> RESULT_LINES == 10'h000;
  endproperty
  a_excl: assert property (p_excl) else $error("pass and fail at once");
  property p_busy;
    out_on |-> !SCAN_READY;
  endproperty
  a_busy: assert property (p_busy) else $error("ready during pulse");
  property p_steady;
    out_on && $past(out_on) |-> $stable(RESULT_LINES);
  endproperty
  a_steady: assert property (p_steady) else $error("lines moved");
  property p_width;
    s_pulse_end |-> hi_cnt_reg != 0 && hi_cnt_reg % (10 * MS_CYCLES) == 0
      && hi_cnt_reg <= 2550 * MS_CYCLES;
  endproperty
  a_width: assert property (p_width) else $error("bad pulse width");
  property p_release;
    s_pulse_end |-> SCAN_READY;
  endproperty
  a_release: assert property (p_release) else $error("not idle");
  property p_gap;
    $fell(SCAN_READY) |-> !out_on;
  endproperty
  a_gap: assert property (p_gap) else $error("lines with no delay");
  property p_num;
    $changed(PRESET_NUM) |-> !SCAN_READY && PRESET_NUM != 5'h00
      && PRESET_NUM <= 5'h10;
  endproperty
  a_num: assert property (p_num) else $error("bad preset number");
endmodule // pmv_sva

bind pmv_top pmv_sva #(.MS_CYCLES(MS_CYCLES)) pmv_sva_inst (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .SCAN_READY(SCAN_READY),
  .RESULT_LINES(RESULT_LINES), .MISMATCH_LINE(MISMATCH_LINE),
  .PRESET_NUM(PRESET_NUM));

// *** tb/pmv_partner.sv ***
// Purpose: scanner feeding strings and receiver timing the result pulse
// Assumes: scanner shares SYS_CLK
// Notes:   character line shows inverted data between strings
`timescale 1ns/1ps
module pmv_partner (
  input  wire logic       sys_clk,
  output logic            scan_valid,
  output logic [7:0]      scan_char,
  output logic            scan_last,
  input  wire logic       scan_ready,
  input  wire logic [9:0] result_lines,
  input  wire logic       mismatch_line
);
  logic [9:0] cap_lines;
  logic       cap_miss;
  logic       rdy_q;
  int         width;
  int         rise_t;
  int         since;
  int         n_idle;
  initial begin
    scan_valid = 1'b0;
    scan_char = 8'h00;
    scan_last = 1'b0;
    rdy_q = 1'b1;
    n_idle = 0;
    since = 0;
  end
  always @(posedge sys_clk) begin
    since <= (scan_valid && scan_ready && scan_last) ? 0 : since + 1;
    rdy_q <= scan_ready;
    if (scan_ready && !rdy_q) n_idle <= n_idle + 1;
    if ((|result_lines) || mismatch_line) begin
      if (width == 0) rise_t <= since;
      width <= width + 1;
      cap_lines <= result_lines;
      cap_miss <= mismatch_line;
    end
  end
  task automatic arm();
    width = 0;
    rise_t = -1;
    cap_lines = 10'h000;
    cap_miss = 1'b0;
  endtask
  // one character per accepted edge, last one flagged
  task automatic send(input string s);
    logic tk;
    for (int i = 0; i < s.len(); i++) begin
      scan_valid <= 1'b1;
      scan_char <= s[i];
      scan_last <= (i == s.len() - 1);
      tk = 1'b0;
      while (!tk) begin
        #1;
        tk = scan_ready;
        @(posedge sys_clk);
      end
    end
    scan_valid <= 1'b0;
    scan_last <= 1'b0;
    scan_char <= ~scan_char;
  endtask
endmodule // pmv_partner

// *** tb/pmv_top_tb.sv ***
// Purpose: self-checking bench of the preset match verifier
// Assumes: short millisecond count so pulses last tens of cycles
// Notes:   registers reached through AXI4-Lite tasks
`timescale 1ns/1ps
module pmv_top_tb;
  localparam int MS = 4;
  logic        sys_clk, reset, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, power_down;
  logic        scan_valid, scan_last, scan_ready, miss;
  logic [7:0]  awaddr, araddr, scan_char;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  strb;
  logic [1:0]  bresp, rresp, resp;
  logic [9:0]  lines;
  logic [4:0]  num;
  int          n_mismatch, total_checks, cyc;
  pmv_top #(.MS_CYCLES(MS)) pmv_top_inst (
    .SYS_CLK(sys_clk), .RESET(reset), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(strb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .SCAN_VALID(scan_valid),
    .SCAN_CHAR(scan_char), .SCAN_LAST(scan_last), .SCAN_READY(scan_ready),
    .POWER_DOWN(power_down), .RESULT_LINES(lines), .MISMATCH_LINE(miss),
    .PRESET_NUM(num));
  pmv_partner pmv_partner_inst (
    .sys_clk(sys_clk), .scan_valid(scan_valid), .scan_char(scan_char),
    .scan_last(scan_last), .scan_ready(scan_ready), .result_lines(lines),
    .mismatch_line(miss));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, e);
    total_checks++;
    if (seen !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb) begin
      #1;
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      resp = bresp;
      @(posedge sys_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  // ready raised only once data shows, so the slave must hold it
  task automatic axr(input logic [7:0] a);
    logic ta, tr, tv;
    tr = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!tr) begin
      #1;
      ta = arvalid && arready;
      tv = rvalid;
      tr = rvalid && rready;
      rd = rdata;
      resp = rresp;
      @(posedge sys_clk);
      if (ta) arvalid <= 1'b0;
      if (tv && !tr) rready <= 1'b1;
    end
    rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
    axr(a);
    chk(nm, rd, e);
  endtask
  task automatic ctl(input logic r, ce, sg, input logic [1:0] e);
    axw(pmv_pkg::A_CTRL, {27'h0, r, ce, sg, e});
  endtask
  task automatic pset(input int idx, input string s);
    for (int i = 0; i < s.len(); i++)
      axw(pmv_pkg::A_PCHAR, 32'((idx << 16) | (i << 8) | s[i]));
    axw(pmv_pkg::A_PLEN, 32'((idx << 16) | s.len()));
  endtask
  // empty string means manual trigger
  task automatic scan(input string s, input logic [9:0] el,
                      input logic em);
    int p;
    p = pmv_partner_inst.n_idle;
    pmv_partner_inst.arm();
    if (s.len() == 0) axw(pmv_pkg::A_TRIG, 32'h1);
    else pmv_partner_inst.send(s);
    while (pmv_partner_inst.n_idle == p) @(posedge sys_clk);
    chk("lines", {22'h0, pmv_partner_inst.cap_lines}, {22'h0, el});
    chk("mismatch", {31'h0, pmv_partner_inst.cap_miss}, {31'h0, em});
  endtask
  initial begin
    {reset, strb} = {1'b1, 4'hf};
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready, power_down} = '0;
    {n_mismatch, total_checks, cyc} = '0;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    rchk(pmv_pkg::A_CTRL, {27'h0, pmv_pkg::CTRL_RST}, "ctrl");
    rchk(pmv_pkg::A_TIME, {16'h0, pmv_pkg::TIME_RST}, "time");
    rchk(pmv_pkg::A_COUNT, 32'h0, "count");
    axr(8'h40);
    chk("rresp", {30'h0, resp}, {30'h0, pmv_pkg::RESP_SLVERR});
    axw(8'h40, 32'h1);
    chk("bresp", {30'h0, resp}, {30'h0, pmv_pkg::RESP_SLVERR});
    strb <= 4'h0;
    axw(pmv_pkg::A_SEL, 32'h5);
    strb <= 4'hf;
    rchk(pmv_pkg::A_SEL, 32'h1, "sel");
    axw(pmv_pkg::A_TIME, 32'h0201);
    pset(1, "AB");
    pset(3, "C?");
    pset(12, "X!");
    scan("AB", 10'h001, 1'b0);
    chk("delay", pmv_partner_inst.rise_t, 2 * MS + 2);
    chk("width", pmv_partner_inst.width, 10 * MS);
    chk("num", {27'h0, num}, 32'h1);
    scan("CZ", 10'h004, 1'b0);
    scan("XYZ", 10'h000, 1'b0);
    chk("num", {27'h0, num}, 32'hc);
    ctl(1'b1, 1'b1, 1'b0, pmv_pkg::ENC_BIN);
    scan("X", 10'h00c, 1'b0);
    ctl(1'b1, 1'b1, 1'b0, pmv_pkg::ENC_BCD);
    scan("XQ", 10'h012, 1'b0);
    scan("QQ", 10'h000, 1'b1);
    scan("A", 10'h000, 1'b1);
    chk("num", {27'h0, num}, 32'hc);
    rchk(pmv_pkg::A_COUNT, 32'h1, "count1");
    axw(pmv_pkg::A_SEL, 32'hc);
    rchk(pmv_pkg::A_COUNT, 32'h3, "count12");
    ctl(1'b1, 1'b1, 1'b1, pmv_pkg::ENC_BCD);
    axw(pmv_pkg::A_SEL, 32'h3);
    scan("AB", 10'h000, 1'b1);
    scan("CK", 10'h001, 1'b0);
    ctl(1'b1, 1'b1, 1'b0, pmv_pkg::ENC_BIT);
    scan("", 10'h004, 1'b0);
    rchk(pmv_pkg::A_COUNT, 32'h3, "count3");
    axw(pmv_pkg::A_COUNT, 32'd999998);
    scan("", 10'h004, 1'b0);
    scan("", 10'h004, 1'b0);
    rchk(pmv_pkg::A_COUNT, 32'd999999, "sat");
    axw(pmv_pkg::A_COUNT, 32'hfffff);
    rchk(pmv_pkg::A_COUNT, 32'd999999, "clamp");
    ctl(1'b1, 1'b0, 1'b0, pmv_pkg::ENC_BIT);
    axw(pmv_pkg::A_COUNT, 32'h7);
    scan("", 10'h004, 1'b0);
    rchk(pmv_pkg::A_COUNT, 32'h7, "cnt_off");
    ctl(1'b0, 1'b1, 1'b0, pmv_pkg::ENC_BIT);
    axw(pmv_pkg::A_PLEN, 32'h0005_0000);
    rchk(pmv_pkg::A_COUNT, 32'h0, "upd_clr");
    for (int k = 0; k < 2; k++) begin
      ctl(k[0], 1'b1, 1'b0, pmv_pkg::ENC_BIT);
      axw(pmv_pkg::A_COUNT, 32'h9);
      power_down <= 1'b1;
      repeat (8) @(posedge sys_clk);
      power_down <= 1'b0;
      repeat (8) @(posedge sys_clk);
      rchk(pmv_pkg::A_COUNT, k ? 32'h9 : 32'h0, "pwr");
    end
    summarize();
  end
endmodule // pmv_top_tb
